// ==== rtl/phy_basic_mode_control.sv ====
// basic mode control register bank with strap and soft-strap handling
`timescale 1ns/1ps
`include "phy_bmc_consts.svh"

module phy_basic_mode_control
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`BMC_ADDR_W-1:0] reg_addr,
    input wire logic [`BMC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`BMC_DATA_W-1:0] reg_rdata,
    input wire phy_bmc_pkg::strap_s strap_pins,
    input wire phy_bmc_pkg::strap_s an_result,
    input wire logic evt_fault,
    input wire logic evt_link_ok,
    input wire logic evt_count,
    input wire logic evt_energy,
    input wire phy_bmc_pkg::mii_nibble_s mii_tx,
    input wire phy_bmc_pkg::mii_nibble_s line_rx,
    output phy_bmc_pkg::mii_nibble_s mii_rx,
    output logic eff_speed_100,
    output logic eff_full_duplex,
    output logic aneg_active,
    output logic soft_reset_busy,
    output logic sws_out
);
    import phy_bmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    localparam logic [7:0] SRST_LAST = 8'(`SRST_CYCLES - 1);

    // defaults for the strap-backed fields
    function automatic strap_s strap_default(input logic latched,
                                             input strap_s cfg,
                                             input strap_s pins);
        begin
            strap_default = latched ? cfg : pins;
        end
    endfunction

    function automatic logic hit(input logic [`BMC_ADDR_W-1:0] a,
                                 input logic [`BMC_ADDR_W-1:0] off);
        begin
            hit = (a == off);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    state_s cur;
    state_s next_cur;

    logic wr_ctrl;
    logic wr_sws;
    logic wr_soft_strap_cfg_bit;
    logic wr_ss;
    logic rd_events;
    logic cfg_done;
    strap_s dflt;
    logic [15:0] rd_val;

    always_comb
    begin
        wr_ctrl = reg_wr && hit(reg_addr, `BMC_OFF_CONTROL);
        wr_sws = reg_wr && hit(reg_addr, `BMC_OFF_SWS);
        wr_soft_strap_cfg_bit = reg_wr && hit(reg_addr, `BMC_OFF_SOFT_STRAP_CFG_BIT) && cur.ss_mode;
        wr_ss = reg_wr && hit(reg_addr, `BMC_OFF_SS_CTRL);
        rd_events = reg_rd && hit(reg_addr, `BMC_OFF_EVENTS);
        cfg_done = wr_ss && cur.ss_mode && reg_wdata[`SS_BIT_DONE];
        dflt = strap_default(cur.cfg_latched, cur.cfg_def, strap_pins);
        next_cur = cur;

        ////////////////////////////////////////////////////////////////////
        // read mux, data returned the cycle after the strobe

        rd_val = 16'h0000;
        if (hit(reg_addr, `BMC_OFF_CONTROL))
        begin
            rd_val[`BMC_BIT_SRST] = cur.srst_busy;
            rd_val[`BMC_BIT_LOOP] = cur.loopback;
            rd_val[`BMC_BIT_SPEED] = cur.mode.speed;
            rd_val[`BMC_BIT_ANEG] = cur.mode.aneg;
            rd_val[`BMC_BIT_DUPLEX] = cur.mode.duplex;
        end
        else if (hit(reg_addr, `BMC_OFF_IDENT))
        begin
            rd_val = `BMC_IDENT_VALUE;
        end
        else if (hit(reg_addr, `BMC_OFF_EVENTS))
        begin
            rd_val[`EVT_BIT_FAULT] = cur.lh_fault;
            rd_val[`EVT_BIT_LINK] = cur.ll_link;
            rd_val[`EVT_BIT_ENERGY] = cur.energy;
            rd_val[`EVT_CNT_MSB:`EVT_CNT_LSB] = cur.cor_cnt;
        end
        else if (hit(reg_addr, `BMC_OFF_SWS))
        begin
            rd_val[0] = cur.sws_val;
        end
        else if (hit(reg_addr, `BMC_OFF_SOFT_STRAP_CFG_BIT))
        begin
            if (cur.ss_mode)
            begin
                rd_val[`SOFT_STRAP_CFG_BIT_BIT_SPEED] = cur.soft_strap_cfg_bit.speed;
                rd_val[`SOFT_STRAP_CFG_BIT_BIT_ANEG] = cur.soft_strap_cfg_bit.aneg;
                rd_val[`SOFT_STRAP_CFG_BIT_BIT_DUPLEX] = cur.soft_strap_cfg_bit.duplex;
            end
        end
        else if (hit(reg_addr, `BMC_OFF_SS_CTRL))
        begin
            rd_val[`SS_BIT_MODE] = cur.ss_mode;
        end
        next_cur.rdata = reg_rd ? rd_val : 16'h0000;

        ////////////////////////////////////////////////////////////////////
        // event fields; a new event wins over the clearing read

        next_cur.energy = evt_energy;
        if (evt_fault)
            next_cur.lh_fault = 1'b1;
        else if (rd_events)
            next_cur.lh_fault = 1'b0;
        if (!evt_link_ok)
            next_cur.ll_link = 1'b0;
        else if (rd_events)
            next_cur.ll_link = 1'b1;
        if (rd_events)
            next_cur.cor_cnt = evt_count ? 8'h01 : 8'h00;
        else if (evt_count && cur.cor_cnt != 8'hFF)
            next_cur.cor_cnt = cur.cor_cnt + 8'h01;

        ////////////////////////////////////////////////////////////////////
        // control fsm and register writes

        unique case (cur.st)
            ST_STRAP:
            begin
                next_cur.mode = dflt;
                next_cur.soft_strap_cfg_bit = strap_pins;
                next_cur.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (wr_ctrl)
                begin
                    next_cur.loopback = reg_wdata[`BMC_BIT_LOOP];
                    next_cur.mode.speed = reg_wdata[`BMC_BIT_SPEED];
                    next_cur.mode.aneg = reg_wdata[`BMC_BIT_ANEG];
                    next_cur.mode.duplex = reg_wdata[`BMC_BIT_DUPLEX];
                    if (reg_wdata[`BMC_BIT_SRST])
                    begin
                        next_cur.st = ST_SRST;
                        next_cur.srst_cnt = 8'h00;
                        next_cur.srst_busy = 1'b1;
                    end
                end
                if (wr_sws)
                begin
                    next_cur.sws_val = reg_wdata[0];
                    next_cur.sws_pend = cur.ss_mode;
                end
                if (wr_soft_strap_cfg_bit)
                begin
                    next_cur.soft_strap_cfg_bit.speed = reg_wdata[`SOFT_STRAP_CFG_BIT_BIT_SPEED];
                    next_cur.soft_strap_cfg_bit.aneg = reg_wdata[`SOFT_STRAP_CFG_BIT_BIT_ANEG];
                    next_cur.soft_strap_cfg_bit.duplex = reg_wdata[`SOFT_STRAP_CFG_BIT_BIT_DUPLEX];
                end
                if (wr_ss)
                    next_cur.ss_mode = reg_wdata[`SS_BIT_MODE];
                if (cfg_done)
                begin
                    next_cur.cfg_latched = 1'b1;
                    next_cur.cfg_def = cur.soft_strap_cfg_bit;
                    next_cur.mode = cur.soft_strap_cfg_bit;
                    if (cur.sws_pend)
                    begin
                        next_cur.sws_def = cur.sws_val;
                        next_cur.sws_pend = 1'b0;
                    end
                end
            end
            ST_SRST:
            begin
                next_cur.srst_cnt = cur.srst_cnt + 8'h01;
                if (cur.srst_cnt == SRST_LAST)
                begin
                    next_cur.st = ST_RUN;
                    next_cur.srst_busy = 1'b0;
                    next_cur.loopback = `BMC_LOOP_RST;
                    next_cur.mode = dflt;
                    next_cur.sws_val = cur.sws_def;
                    next_cur.sws_pend = 1'b0;
                    next_cur.ss_mode = 1'b0;
                    next_cur.soft_strap_cfg_bit = dflt;
                    next_cur.srst_cnt = 8'h00;
                end
            end
            default:
            begin
                next_cur.st = ST_STRAP;
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // datapath outputs

        if (cur.loopback)
            next_cur.rx = mii_tx;
        else
            next_cur.rx = line_rx;
        next_cur.aneg_active = cur.mode.aneg;
        if (cur.mode.aneg)
        begin
            next_cur.eff_speed_100 = an_result.speed;
            next_cur.eff_full_duplex = an_result.duplex;
        end
        else
        begin
            next_cur.eff_speed_100 = cur.mode.speed;
            next_cur.eff_full_duplex = cur.mode.duplex;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cur <= '0;
            cur.st <= ST_STRAP;
            cur.ll_link <= 1'b1;
            cur.mode <= '1;
            cur.soft_strap_cfg_bit <= '1;
            cur.sws_val <= `BMC_SWS_RST;
            cur.sws_def <= `BMC_SWS_RST;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign mii_rx = cur.rx;
    assign eff_speed_100 = cur.eff_speed_100;
    assign eff_full_duplex = cur.eff_full_duplex;
    assign aneg_active = cur.aneg_active;
    assign soft_reset_busy = cur.srst_busy;
    assign sws_out = cur.sws_val;

endmodule // phy_basic_mode_control

// ==== rtl/phy_bmc_consts.svh ====
// offsets, field positions, reset values and timing counts
`ifndef PHY_BMC_CONSTS_SVH
`define PHY_BMC_CONSTS_SVH

`define BMC_ADDR_W 5
`define BMC_DATA_W 16

`define BMC_OFF_CONTROL 5'h00
`define BMC_OFF_IDENT 5'h02
`define BMC_OFF_EVENTS 5'h11
`define BMC_OFF_SWS 5'h1D
`define BMC_OFF_SOFT_STRAP_CFG_BIT 5'h1E
`define BMC_OFF_SS_CTRL 5'h1F

`define BMC_BIT_SRST 15
`define BMC_BIT_LOOP 14
`define BMC_BIT_SPEED 13
`define BMC_BIT_ANEG 12
`define BMC_BIT_DUPLEX 8

`define EVT_BIT_FAULT 0
`define EVT_BIT_LINK 1
`define EVT_BIT_ENERGY 2
`define EVT_CNT_LSB 8
`define EVT_CNT_MSB 15

`define SOFT_STRAP_CFG_BIT_BIT_SPEED 2
`define SOFT_STRAP_CFG_BIT_BIT_ANEG 1
`define SOFT_STRAP_CFG_BIT_BIT_DUPLEX 0

`define SS_BIT_MODE 0
`define SS_BIT_DONE 1

`define BMC_IDENT_VALUE 16'h5A3C
`define BMC_LOOP_RST 1'h0
`define BMC_SWS_RST 1'h0

`define CLK_PERIOD_PS 5000
`define SRST_TIME_NS 1000
`define SRST_CYCLES ((`SRST_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ==== rtl/phy_bmc_pkg.sv ====
// types shared by the basic mode control block
package phy_bmc_pkg;

    typedef enum logic [1:0] {
        ST_STRAP = 2'h0,
        ST_RUN = 2'h1,
        ST_SRST = 2'h3
    } ctrl_state_e;

    typedef struct packed {
        logic speed;
        logic aneg;
        logic duplex;
    } strap_s;

    typedef struct packed {
        logic en;
        logic [3:0] data;
    } mii_nibble_s;

    typedef struct packed {
        ctrl_state_e st;
        logic [7:0] srst_cnt;
        logic loopback;
        strap_s mode;
        logic lh_fault;
        logic ll_link;
        logic [7:0] cor_cnt;
        logic ss_mode;
        strap_s soft_strap_cfg_bit;
        logic cfg_latched;
        strap_s cfg_def;
        logic sws_val;
        logic sws_def;
        logic sws_pend;
        logic [15:0] rdata;
        mii_nibble_s rx;
        logic eff_speed_100;
        logic eff_full_duplex;
        logic aneg_active;
        logic srst_busy;
        logic energy;
    } state_s;

endpackage

// ==== sim/phy_bmc_properties.sv ====
// port assertions for the basic mode control block
`timescale 1ns/1ps
`include "phy_bmc_consts.svh"

module phy_bmc_properties
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [`BMC_ADDR_W-1:0] reg_addr,
    input wire logic [`BMC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`BMC_DATA_W-1:0] reg_rdata,
    input wire phy_bmc_pkg::strap_s an_result,
    input wire logic evt_fault,
    input wire logic evt_link_ok,
    input wire logic evt_count,
    input wire phy_bmc_pkg::mii_nibble_s mii_tx,
    input wire phy_bmc_pkg::mii_nibble_s line_rx,
    input wire phy_bmc_pkg::mii_nibble_s mii_rx,
    input wire logic eff_speed_100,
    input wire logic eff_full_duplex,
    input wire logic aneg_active,
    input wire logic soft_reset_busy
);
    import phy_bmc_pkg::*;
    logic srst_wr_q;
    logic evt_rd;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    assign evt_rd = reg_rd && reg_addr == `BMC_OFF_EVENTS;
    always_ff @(posedge clk_sys)
    begin
        srst_wr_q <= reg_wr && reg_addr == `BMC_OFF_CONTROL &&
            reg_wdata[`BMC_BIT_SRST];
    end
////////////////////////////////////////////////////////////////////////////////
    AST_IDENT: assert property (
        reg_rd && reg_addr == `BMC_OFF_IDENT |=>
        reg_rdata == `BMC_IDENT_VALUE) else $error("ident read wrong");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read slot");
    AST_FAULT_LATCH: assert property (
        evt_rd && $past(evt_fault) |=>
        reg_rdata[0]) else $error("fault not latched");
    AST_LINK_LATCH: assert property (
        evt_rd && !$past(evt_link_ok) |=>
        !reg_rdata[1]) else $error("link loss not latched");
    AST_COR_CLEAR: assert property (
        (evt_rd && !evt_count && !evt_fault)
        ##1 evt_rd |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[0])
        else $error("read did not clear");
    AST_SRST_HOLD: assert property (
        $rose(soft_reset_busy) |->
        soft_reset_busy[*8]) else $error("soft reset too short");
    AST_SRST_DONE: assert property (
        $rose(soft_reset_busy) |->
        ##[190:210] $fell(soft_reset_busy)) else $error("soft reset end");
    AST_SRST_CAUSE: assert property (
        $rose(soft_reset_busy) |->
        srst_wr_q || $past(srst_wr_q)) else $error("soft reset uncaused");
    AST_SRST_READ: assert property (
        reg_rd && reg_addr == `BMC_OFF_CONTROL && soft_reset_busy |=>
        reg_rdata[`BMC_BIT_SRST]) else $error("reset bit not read as one");
    AST_ANEG_RATE: assert property (
        $past(rst_n) && aneg_active |->
        eff_speed_100 == $past(an_result.speed) &&
        eff_full_duplex == $past(an_result.duplex)) else $error("aneg rate");
    AST_RX_PATH: assert property (
        $past(rst_n) |-> mii_rx == $past(mii_tx)
        || mii_rx == $past(line_rx)) else $error("receive path source");
    cover property ($rose(soft_reset_busy));
    cover property (evt_rd && $past(evt_fault));
    cover property ($rose(aneg_active));
endmodule // phy_bmc_properties

// ==== sim/mac_partner.sv ====
// MAC side: transmit nibble source
`timescale 1ns/1ps

module mac_partner
(
    input wire logic clk_sys,
    input wire logic rst_n,
    output phy_bmc_pkg::mii_nibble_s mii_tx
);
    import phy_bmc_pkg::*;
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            mii_tx <= '0;
        else
            mii_tx <= '{en: ~mii_tx.en, data: mii_tx.data + 4'h3};
    end
endmodule // mac_partner

// ==== sim/testbench.sv ====
// self-checking bench for the basic mode control block
`timescale 1ns/1ps
`include "phy_bmc_consts.svh"

module testbench;
    import phy_bmc_pkg::*;
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [4:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0, reg_rdata;
    strap_s strap_pins = '0, an_result = '0, v;
    logic evt_fault = 0, evt_link_ok = 1, evt_count = 0, evt_energy = 0;
    mii_nibble_s mii_tx, line_rx = '0, mii_rx, tx_q, rx_q;
    logic eff_speed_100, eff_full_duplex, aneg_active, soft_reset_busy, sws_out;
    int num_errors = 0, compares = 0, cycles = 0, seed = 44314, n, i;

    phy_basic_mode_control uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_pins(strap_pins),
        .an_result(an_result), .evt_fault(evt_fault),
        .evt_link_ok(evt_link_ok), .evt_count(evt_count),
        .evt_energy(evt_energy), .mii_tx(mii_tx), .line_rx(line_rx),
        .mii_rx(mii_rx), .eff_speed_100(eff_speed_100),
        .eff_full_duplex(eff_full_duplex), .aneg_active(aneg_active),
        .soft_reset_busy(soft_reset_busy), .sws_out(sws_out));
    mac_partner mac (.clk_sys(clk_sys), .rst_n(rst_n), .mii_tx(mii_tx));

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        tx_q <= mii_tx;
        rx_q <= line_rx;
        line_rx <= 5'($random(seed));
        an_result <= 3'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            close_out;
        end
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic wr(logic [4:0] a, logic [15:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 0;
        #1;
    endtask
    task automatic rd(logic [4:0] a, logic [15:0] exp);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask
    task automatic watch(logic lb);
        repeat (6)
        begin
            @(posedge clk_sys);
            #1;
            check("mii_rx", mii_rx, lb ? tx_q : rx_q);
        end
    endtask
    function automatic logic [15:0] ctrl(strap_s s);
        return {2'b00, s.speed, s.aneg, 3'b000, s.duplex, 8'h00};
    endfunction
    task automatic do_reset;
        rst_n <= 0;
        strap_pins <= 3'($random(seed));
        tick(12);
        rst_n <= 1;
        tick(2);
        rd(`BMC_OFF_CONTROL, ctrl(strap_pins));
    endtask
    task automatic close_out;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        do_reset;
        rd(`BMC_OFF_IDENT, `BMC_IDENT_VALUE);
        wr(`BMC_OFF_IDENT, 16'h0000);
        rd(`BMC_OFF_IDENT, `BMC_IDENT_VALUE);
        rd(5'h07, 16'h0000);
        for (n = 0; n < 4; n++)
        begin
            v = {n[1], 1'b0, n[0]};
            wr(`BMC_OFF_CONTROL, ctrl(v));
            tick(3);
            check("eff_speed_100", eff_speed_100, n[1]);
            check("eff_full_duplex", eff_full_duplex, n[0]);
            check("aneg_active", aneg_active, 0);
        end
        wr(`BMC_OFF_CONTROL, 16'h1000);
        tick(3);
        check("aneg_active", aneg_active, 1);
        wr(`BMC_OFF_CONTROL, 16'h4000);
        tick(3);
        watch(1);
        wr(`BMC_OFF_CONTROL, 16'h0000);
        tick(3);
        watch(0);
        n = 1 + ($random(seed) & 3);
        evt_fault <= 1;
        evt_link_ok <= 0;
        evt_energy <= 1;
        tick(1);
        evt_fault <= 0;
        evt_link_ok <= 1;
        for (i = 0; i < n; i++)
        begin
            evt_count <= 1;
            tick(1);
            evt_count <= 0;
            tick(1);
        end
        tick(2);
        rd(`BMC_OFF_EVENTS, {n[7:0], 8'h05});
        rd(`BMC_OFF_EVENTS, 16'h0006);
        evt_energy <= 0;
        tick(3);
        rd(`BMC_OFF_EVENTS, 16'h0002);
        v = 3'($random(seed));
        wr(`BMC_OFF_SS_CTRL, 16'h0001);
        rd(`BMC_OFF_SOFT_STRAP_CFG_BIT, {13'h0000, strap_pins});
        wr(`BMC_OFF_SOFT_STRAP_CFG_BIT, {13'h0000, v});
        rd(`BMC_OFF_SOFT_STRAP_CFG_BIT, {13'h0000, v});
        wr(`BMC_OFF_SWS, 16'h0001);
        wr(`BMC_OFF_SS_CTRL, 16'h0003);
        tick(2);
        rd(`BMC_OFF_CONTROL, ctrl(v));
        wr(`BMC_OFF_SS_CTRL, 16'h0000);
        rd(`BMC_OFF_SOFT_STRAP_CFG_BIT, 16'h0000);
        wr(`BMC_OFF_CONTROL, 16'hC000);
        rd(`BMC_OFF_CONTROL, 16'hC000);
        check("soft_reset_busy", soft_reset_busy, 1);
        n = 0;
        while (soft_reset_busy === 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("busy_cycles", 16'(n), 16'(`SRST_CYCLES - 1));
        tick(2);
        rd(`BMC_OFF_CONTROL, ctrl(v));
        rd(`BMC_OFF_SWS, 16'h0001);
        check("sws_out", sws_out, 1);
        do_reset;
        rd(`BMC_OFF_SWS, 16'h0000);
        close_out;
    end
endmodule // testbench

bind phy_basic_mode_control phy_bmc_properties chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .an_result(an_result), .evt_fault(evt_fault), .evt_link_ok(evt_link_ok),
    .evt_count(evt_count), .mii_tx(mii_tx), .line_rx(line_rx),
    .mii_rx(mii_rx), .eff_speed_100(eff_speed_100),
    .eff_full_duplex(eff_full_duplex), .aneg_active(aneg_active),
    .soft_reset_busy(soft_reset_busy));
